// ==== rtl/bxc_config_regs.sv ====
// Extension configuration registers, self reset and two-tier arbiter of the bridge
// Operation
// R1 - Writing 1 to diagnostic bit 0 sets bridge control bit 6, then resets internally.
// R2 - The internal reset leaves bridge control bit 6 set.
// R3 - Diagnostic bit 0 clears itself and always reads back zero.
// R4 - Diagnostic bits 7..1 read zero; register resets to 00h.
// R5 - Arbiter uses two tiers, rotating fairly among requesters within each tier.
// R6 - Arbiter bit 9 puts bridge in low tier (0) or high tier (1); resets 1.
// R7 - Arbiter bits 0..3 put grant lines 0..3 in low or high tier; reset 0.
// R8 - Arbiter register resets to 0200h; bits 15..10 and 8..4 read zero.
// R9 - Two windows, each with 32-bit base and limit, all reset to zero.
// R10 - Limit bits 1:0 select non-prefetchable, prefetchable memory, or I/O window.
// R11 - Memory windows decode at 4 KB granularity, I/O windows at 4 bytes.
// R12 - Memory decode treats bits 11..2 as ones in limit, zeros in base.
// R13 - A window decodes only when its enable bit is set; enables reset disabled.
// R14 - Map bits choose inclusion or exclusion of each window in primary decode.
// R15 - Access is by configuration cycles; values survive the D3 to D0 transition.
// R16 - Enabled window matches addresses from effective base to effective limit inclusive.
`default_nettype none
module bxc_config_regs
   import bxc_pkg::*;
(
   input  wire logic         clk_in,
   input  wire logic         reset_in,
   input  wire bxc_cfg_req_s cfg_req_in,
   output logic              cfg_ack_out,
   output logic [31:0]       cfg_rdata_out,
   input  wire logic         bridge_ctl_bit6_clear_in,
   output logic              bridge_ctl_bit6_out,
   output logic              internal_reset_out,
   input  wire logic [4:0]   request_in,
   output logic              bridge_grant_out,
   output logic              secondary_grant_line_0_out,
   output logic              secondary_grant_line_1_out,
   output logic              secondary_grant_line_2_out,
   output logic              secondary_grant_line_3_out,
   input  wire bxc_txn_s     txn_in,
   output logic [1:0]        window_hit_out,
   output logic [1:0]        window_primary_claim_out,
   output logic [1:0]        window_prefetch_out
);
   // ==========================================================
   // State
   bxc_state_s  state;
   bxc_state_s  next_state;
   logic [1:0]  hit;
   logic [1:0]  claim;
   logic [1:0]  prefetch;

   // ==========================================================
   // Helpers
   function automatic logic [31:0] merge_bytes(input logic [31:0] old_value,
                                               input logic [31:0] new_value,
                                               input logic [3:0]  byte_en);
      logic [31:0] result;
      result = old_value;
      for (int i = 0; i < 4; i++) begin
         if (byte_en[i]) begin
            result[i*8 +: 8] = new_value[i*8 +: 8];
         end
      end
      return result;
   endfunction

   // Next requester after last in the given set, rotating
   function automatic logic [3:0] pick_next(input logic [4:0] reqs,
                                            input logic [2:0] last);
      logic [3:0] result;
      logic [2:0] idx;
      result = 4'h0;
      idx    = last;
      for (int k = 0; k < NUM_REQ; k++) begin
         idx = (idx == 3'(NUM_REQ - 1)) ? 3'h0 : 3'(idx + 3'h1);
         if (!result[3] && reqs[idx]) begin
            result = {1'b1, idx};
         end
      end
      return result;
   endfunction

   // ==========================================================
   // Window decoders
   bxc_window_match u_window0 (
      .base_in           (state.base0),
      .limit_in          (state.limit0),
      .enable_in         (state.win_en[0]),
      .exclude_in        (state.win_map[0]),
      .txn_in            (txn_in),
      .hit_out           (hit[0]),
      .primary_claim_out (claim[0]),
      .prefetch_out      (prefetch[0])
   );

   bxc_window_match u_window1 (
      .base_in           (state.base1),
      .limit_in          (state.limit1),
      .enable_in         (state.win_en[1]),
      .exclude_in        (state.win_map[1]),
      .txn_in            (txn_in),
      .hit_out           (hit[1]),
      .primary_claim_out (claim[1]),
      .prefetch_out      (prefetch[1])
   );

   // ==========================================================
   // Next state
   always_comb begin
      logic        in_reset;
      logic        wr;
      logic        rd;
      logic [31:0] rd_word;
      logic [31:0] wword;
      logic [4:0]  tier_high;
      logic [4:0]  reqs;
      logic [3:0]  pick;

      next_state = state;
      in_reset   = (state.sr == SR_RESET);
      wr         = cfg_req_in.valid && cfg_req_in.write && !in_reset;       // R15
      rd         = cfg_req_in.valid && !cfg_req_in.write;
      rd_word    = 32'h0000_0000;
      wword      = 32'h0000_0000;
      tier_high  = 5'h00;
      reqs       = 5'h00;
      pick       = 4'h0;

      // Pin synchroniser
      next_state.req_s1 = request_in;
      next_state.req_s2 = state.req_s1;

      // Bridge control bit 6 lives outside the internal reset
      if (bridge_ctl_bit6_clear_in) begin
         next_state.bit6 = 1'b0;
      end

      // Self reset sequence
      // Bit 6 is set on the same clock edge that starts the internal reset
      case (state.sr)
         SR_IDLE: begin
            if (wr && cfg_req_in.offset[7:2] == OFS_DIAG[7:2] && cfg_req_in.byte_en[1] &&
                cfg_req_in.wdata[8 + DIAG_RESET_BIT]) begin
               next_state.sr = SR_SET_BIT6;                                   // R1
            end
         end
         SR_SET_BIT6: begin
            next_state.bit6     = 1'b1;                                       // R1
            next_state.sr       = SR_RESET;
            next_state.sr_count = 5'(SELF_RESET_CYC - 1);
         end
         SR_RESET: begin
            if (state.sr_count == 5'h00) begin
               next_state.sr = SR_IDLE;
            end else begin
               next_state.sr_count = state.sr_count - 5'h01;
            end
         end
         default: begin
            next_state.sr = SR_IDLE;
         end
      endcase

      // Configuration writes
      // Writes are dropped while the internal reset runs
      if (wr) begin
         case (cfg_req_in.offset[7:2])
            OFS_ARB[7:2]: begin
               wword = merge_bytes({state.arb, 16'h0000}, cfg_req_in.wdata,
                                   {cfg_req_in.byte_en[3:2], 2'b00});
               next_state.arb = wword[31:16] & ARB_RW_MASK;                  // R6 R7 R8
            end
            OFS_BASE0[7:2]: begin
               wword = merge_bytes(state.base0, cfg_req_in.wdata, cfg_req_in.byte_en);
               next_state.base0 = {wword[31:BASE_RO_LSB], 2'b00};            // R9
            end
            OFS_LIMIT0[7:2]: begin
               next_state.limit0 = merge_bytes(state.limit0, cfg_req_in.wdata,
                                               cfg_req_in.byte_en);          // R9
            end
            OFS_BASE1[7:2]: begin
               wword = merge_bytes(state.base1, cfg_req_in.wdata, cfg_req_in.byte_en);
               next_state.base1 = {wword[31:BASE_RO_LSB], 2'b00};            // R9
            end
            OFS_LIMIT1[7:2]: begin
               next_state.limit1 = merge_bytes(state.limit1, cfg_req_in.wdata,
                                               cfg_req_in.byte_en);          // R9
            end
            OFS_WIN_EN[7:2]: begin
               if (cfg_req_in.byte_en[0]) begin
                  next_state.win_en = cfg_req_in.wdata[1:0] & WIN_RW_MASK;   // R13
               end
               if (cfg_req_in.byte_en[1]) begin
                  next_state.win_map = cfg_req_in.wdata[9:8] & WIN_RW_MASK;  // R14
               end
            end
            default: begin
            end
         endcase
      end

      // Configuration reads
      // Diagnostic byte is write-only and reads zero
      case (cfg_req_in.offset[7:2])
         OFS_DIAG[7:2]:   rd_word = {state.arb, 8'h00, 8'h00};                // R3 R4 R8
         OFS_BASE0[7:2]:  rd_word = state.base0;
         OFS_LIMIT0[7:2]: rd_word = state.limit0;
         OFS_BASE1[7:2]:  rd_word = state.base1;
         OFS_LIMIT1[7:2]: rd_word = state.limit1;
         OFS_WIN_EN[7:2]: rd_word = {16'h0000, 6'h00, state.win_map, 6'h00, state.win_en};
         default:         rd_word = 32'h0000_0000;
      endcase
      next_state.ack   = cfg_req_in.valid;
      next_state.rdata = (rd && !in_reset) ? rd_word : 32'h0000_0000;

      // Two-tier rotating arbiter
      // Low tier is served only when no high-tier line requests
      tier_high = {state.arb[ARB_BRIDGE_BIT], state.arb[3:0]};                // R6 R7
      reqs      = state.req_s2;
      if ((state.grant & reqs) == 5'h00) begin
         next_state.grant = 5'h00;
         pick = pick_next(reqs & tier_high, state.hi_last);                  // R5
         if (pick[3]) begin
            next_state.grant  = 5'(5'h01 << pick[2:0]);
            next_state.hi_last = pick[2:0];
         end else begin
            pick = pick_next(reqs & ~tier_high, state.lo_last);              // R5
            if (pick[3]) begin
               next_state.grant  = 5'(5'h01 << pick[2:0]);
               next_state.lo_last = pick[2:0];
            end
         end
      end

      // Registered decode results
      // Held one cycle to line up with the address
      next_state.win_hit      = hit;
      next_state.win_claim    = claim;
      next_state.win_prefetch = prefetch;

      // Internal reset returns all but bit 6, the sequencer, the pin synchroniser and the ack
      if (in_reset) begin
         next_state.arb     = ARB_RESET;                                      // R8
         next_state.base0   = WIN_ADDR_RESET;
         next_state.limit0  = WIN_ADDR_RESET;
         next_state.base1   = WIN_ADDR_RESET;
         next_state.limit1  = WIN_ADDR_RESET;
         next_state.win_en  = WIN_CTL_RESET;
         next_state.win_map = WIN_CTL_RESET;
         next_state.grant   = 5'h00;
         next_state.hi_last = 3'(BRIDGE_REQ);
         next_state.lo_last = 3'(BRIDGE_REQ);
         next_state.win_hit   = 2'h0;
         next_state.win_claim = 2'h0;
         next_state.win_prefetch = 2'h0;
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         state.sr           <= SR_IDLE;
         state.sr_count     <= 5'h00;
         state.bit6         <= 1'b0;
         state.arb          <= ARB_RESET;                                     // R8
         state.base0        <= WIN_ADDR_RESET;                                // R9
         state.limit0       <= WIN_ADDR_RESET;
         state.base1        <= WIN_ADDR_RESET;
         state.limit1       <= WIN_ADDR_RESET;
         state.win_en       <= WIN_CTL_RESET;                                 // R13
         state.win_map      <= WIN_CTL_RESET;
         state.ack          <= 1'b0;
         state.rdata        <= 32'h0000_0000;
         state.grant        <= 5'h00;
         state.hi_last      <= 3'(BRIDGE_REQ);
         state.lo_last      <= 3'(BRIDGE_REQ);
         state.req_s1       <= 5'h00;
         state.req_s2       <= 5'h00;
         state.win_hit      <= 2'h0;
         state.win_claim    <= 2'h0;
         state.win_prefetch <= 2'h0;
      end else begin
         state <= next_state;                                                 // R2 R15
      end
   end

   // ==========================================================
   // Outputs
   assign cfg_ack_out                = state.ack;
   assign cfg_rdata_out              = state.rdata;
   assign bridge_ctl_bit6_out        = state.bit6;                            // R2
   assign internal_reset_out         = (state.sr == SR_RESET);                // R1
   assign bridge_grant_out           = state.grant[BRIDGE_REQ];
   assign secondary_grant_line_0_out = state.grant[0];
   assign secondary_grant_line_1_out = state.grant[1];
   assign secondary_grant_line_2_out = state.grant[2];
   assign secondary_grant_line_3_out = state.grant[3];
   assign window_hit_out             = state.win_hit;
   assign window_primary_claim_out   = state.win_claim;
   assign window_prefetch_out        = state.win_prefetch;
endmodule // bxc_config_regs
`default_nettype wire

// ==== rtl/bxc_pkg.sv ====
// Package with offsets, layouts, reset values and types of the extension registers
`default_nettype none
package bxc_pkg;
   // ==========================================================
   // Register byte offsets in configuration space
   localparam logic [7:0]  OFS_CHIP_CTL   = 8'h40;
   localparam logic [7:0]  OFS_DIAG       = 8'h41;
   localparam logic [7:0]  OFS_ARB        = 8'h42;
   localparam logic [7:0]  OFS_BASE0      = 8'h44;
   localparam logic [7:0]  OFS_LIMIT0     = 8'h48;
   localparam logic [7:0]  OFS_BASE1      = 8'h4c;
   localparam logic [7:0]  OFS_LIMIT1     = 8'h50;
   localparam logic [7:0]  OFS_WIN_EN     = 8'h54;
   localparam logic [7:0]  OFS_WIN_MAP    = 8'h55;
   // ==========================================================
   // Field positions
   localparam int          DIAG_RESET_BIT = 0;
   localparam int          ARB_BRIDGE_BIT = 9;
   localparam int          BASE_RO_LSB    = 2;
   localparam logic [15:0] ARB_RW_MASK    = 16'h020f;
   localparam logic [1:0]  WIN_RW_MASK    = 2'h3;
   localparam int          MEM_GRAN_BITS  = 12;
   localparam int          IO_GRAN_BITS   = 2;
   // ==========================================================
   // Reset values
   localparam logic [7:0]  DIAG_RESET     = 8'h00;
   localparam logic [15:0] ARB_RESET      = 16'h0200;
   localparam logic [31:0] WIN_ADDR_RESET = 32'h0000_0000;
   localparam logic [1:0]  WIN_CTL_RESET  = 2'h0;
   // ==========================================================
   // Timing
   localparam int          CLK_PERIOD_NS  = 10;
   localparam int          SELF_RESET_NS  = 160;
   localparam int          SELF_RESET_CYC = (SELF_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          NUM_REQ        = 5;
   localparam int          BRIDGE_REQ     = 4;
   // ==========================================================
   // Types
   typedef enum logic [1:0] {SR_IDLE, SR_SET_BIT6, SR_RESET} bxc_sr_e;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [7:0]  offset;
      logic [3:0]  byte_en;
      logic [31:0] wdata;
   } bxc_cfg_req_s;

   typedef struct packed {
      logic [31:0] addr;
      logic        is_io;
   } bxc_txn_s;

   typedef struct packed {
      bxc_sr_e     sr;
      logic [4:0]  sr_count;
      logic        bit6;
      logic [15:0] arb;
      logic [31:0] base0;
      logic [31:0] limit0;
      logic [31:0] base1;
      logic [31:0] limit1;
      logic [1:0]  win_en;
      logic [1:0]  win_map;
      logic        ack;
      logic [31:0] rdata;
      logic [4:0]  grant;
      logic [2:0]  hi_last;
      logic [2:0]  lo_last;
      logic [4:0]  req_s1;
      logic [4:0]  req_s2;
      logic [1:0]  win_hit;
      logic [1:0]  win_claim;
      logic [1:0]  win_prefetch;
   } bxc_state_s;
endpackage : bxc_pkg
`default_nettype wire

// ==== rtl/bxc_window_match.sv ====
// Address range match of one extension window
`default_nettype none
module bxc_window_match
   import bxc_pkg::*;
(
   input  wire logic [31:0] base_in,
   input  wire logic [31:0] limit_in,
   input  wire logic        enable_in,
   input  wire logic        exclude_in,
   input  wire bxc_txn_s    txn_in,
   output logic             hit_out,
   output logic             primary_claim_out,
   output logic             prefetch_out
);
   // ==========================================================
   // Effective range
   logic        win_is_io;
   logic [31:0] eff_base;
   logic [31:0] eff_limit;
   logic        in_range;

   assign win_is_io = limit_in[1];                                          // R10
   always_comb begin
      if (win_is_io) begin
         eff_base  = {base_in[31:IO_GRAN_BITS], {IO_GRAN_BITS{1'b0}}};      // R11
         eff_limit = {limit_in[31:IO_GRAN_BITS], {IO_GRAN_BITS{1'b1}}};     // R11
      end else begin
         eff_base  = {base_in[31:MEM_GRAN_BITS], {MEM_GRAN_BITS{1'b0}}};    // R12
         eff_limit = {limit_in[31:MEM_GRAN_BITS], {MEM_GRAN_BITS{1'b1}}};   // R12
      end
   end

   assign in_range = (txn_in.addr >= eff_base) && (txn_in.addr <= eff_limit);     // R16
   assign hit_out  = enable_in && (txn_in.is_io == win_is_io) && in_range;       // R13 R16
   assign primary_claim_out = hit_out && !exclude_in;                           // R14
   assign prefetch_out      = !win_is_io && limit_in[0];                        // R10
endmodule // bxc_window_match
`default_nettype wire

// ==== tb/bxc_config_regs_monitor.sv ====
// Port checker of the extension register block, bound to its top module
`default_nettype none
module bxc_config_regs_monitor
   import bxc_pkg::*;
(
   input  wire logic         clk_in,
   input  wire logic         reset_in,
   input  wire bxc_cfg_req_s cfg_req_in,
   input  wire logic         cfg_ack_out,
   input  wire logic [31:0]  cfg_rdata_out,
   input  wire logic         bridge_ctl_bit6_clear_in,
   input  wire logic         bridge_ctl_bit6_out,
   input  wire logic         internal_reset_out,
   input  wire logic [4:0]   request_in,
   input  wire logic         bridge_grant_out,
   input  wire logic         secondary_grant_line_0_out,
   input  wire logic         secondary_grant_line_1_out,
   input  wire logic         secondary_grant_line_2_out,
   input  wire logic         secondary_grant_line_3_out,
   input  wire bxc_txn_s     txn_in,
   input  wire logic [1:0]   window_hit_out,
   input  wire logic [1:0]   window_primary_claim_out,
   input  wire logic [1:0]   window_prefetch_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // Helper decode
   logic       rd_dw40;
   logic       rd_base;
   logic       diag_go;
   logic [4:0] grant_vec;
   logic [5:0] ir_cnt;
   assign rd_dw40 = cfg_req_in.valid && !cfg_req_in.write && cfg_req_in.offset[7:2] == 6'h10;
   assign rd_base = cfg_req_in.valid && !cfg_req_in.write
                    && (cfg_req_in.offset[7:2] == 6'h11 || cfg_req_in.offset[7:2] == 6'h13);
   assign diag_go = cfg_req_in.valid && cfg_req_in.write && cfg_req_in.offset[7:2] == 6'h10
                    && cfg_req_in.byte_en[1] && cfg_req_in.wdata[8] && !internal_reset_out;
   assign grant_vec = {bridge_grant_out, secondary_grant_line_3_out, secondary_grant_line_2_out,
                       secondary_grant_line_1_out, secondary_grant_line_0_out};
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         ir_cnt <= 6'h00;
      end else if (internal_reset_out) begin
         ir_cnt <= ir_cnt + 6'h01;
      end else begin
         ir_cnt <= 6'h00;
      end
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);
   // ==========================================================
   // Assertions
   a_ack_next_cycle: assert property (cfg_ack_out == $past(cfg_req_in.valid))
      else $error("ack not one cycle after request");
   a_diag_starts_reset: assert property (diag_go |-> ##2 (bridge_ctl_bit6_out && internal_reset_out))
      else $error("diagnostic write did not set bit 6 and reset");
   a_bit6_before_reset: assert property ($rose(internal_reset_out) |-> bridge_ctl_bit6_out)
      else $error("internal reset without bit 6 set");
   a_reset_length: assert property ($fell(internal_reset_out) && !$past(reset_in)
                                    |-> ir_cnt == SELF_RESET_CYC)
      else $error("internal reset length wrong");
   a_bit6_survives: assert property (internal_reset_out && bridge_ctl_bit6_out
                                     && !bridge_ctl_bit6_clear_in |=> bridge_ctl_bit6_out)
      else $error("bit 6 lost during internal reset");
   a_diag_reads_zero: assert property (rd_dw40 |=> cfg_rdata_out[15:0] == 16'h0000)
      else $error("diagnostic byte read nonzero");
   a_arb_reserved_zero: assert property (rd_dw40 |=> (cfg_rdata_out[31:16] & ~ARB_RW_MASK) == 16'h0000)
      else $error("arbiter reserved bits nonzero");
   a_base_low_zero: assert property (rd_base |=> cfg_rdata_out[1:0] == 2'h0)
      else $error("base bits 1:0 read nonzero");
   a_grant_one_hot: assert property ($onehot0(grant_vec))
      else $error("more than one grant");
   a_grant_has_request: assert property ((grant_vec & ~$past(request_in, 3)) == 5'h00)
      else $error("grant without request");
   a_claim_within_hit: assert property ((window_primary_claim_out & ~window_hit_out) == 2'h0)
      else $error("primary claim without window hit");
   // ==========================================================
   // Covers
   c_diag_write: cover property (diag_go ##2 internal_reset_out);
   c_bridge_grant: cover property (bridge_grant_out);
   c_window_claim: cover property (window_primary_claim_out != 2'h0);
endmodule // bxc_config_regs_monitor

bind bxc_config_regs bxc_config_regs_monitor u_mon (
   .clk_in(clk_in), .reset_in(reset_in), .cfg_req_in(cfg_req_in), .cfg_ack_out(cfg_ack_out),
   .cfg_rdata_out(cfg_rdata_out), .bridge_ctl_bit6_clear_in(bridge_ctl_bit6_clear_in),
   .bridge_ctl_bit6_out(bridge_ctl_bit6_out), .internal_reset_out(internal_reset_out),
   .request_in(request_in), .bridge_grant_out(bridge_grant_out),
   .secondary_grant_line_0_out(secondary_grant_line_0_out),
   .secondary_grant_line_1_out(secondary_grant_line_1_out),
   .secondary_grant_line_2_out(secondary_grant_line_2_out),
   .secondary_grant_line_3_out(secondary_grant_line_3_out), .txn_in(txn_in),
   .window_hit_out(window_hit_out), .window_primary_claim_out(window_primary_claim_out),
   .window_prefetch_out(window_prefetch_out));
`default_nettype wire

// ==== tb/bxc_host_model.sv ====
// Host model issuing configuration reads and writes
`default_nettype none
module bxc_host_model
   import bxc_pkg::*;
(
   input  wire logic        clk_in,
   output var bxc_cfg_req_s cfg_req_out,
   input  wire logic        cfg_ack_in,
   input  wire logic [31:0] cfg_rdata_in
);
   timeunit 1ns;
   timeprecision 1ps;
   initial cfg_req_out = '0;
   // ==========================================================
   // One access: request for one edge, answer taken one cycle later
   task automatic access(input logic wr, input logic [7:0] ofs, input logic [3:0] be,
                         input logic [31:0] wd, output logic [31:0] rd, output logic ok);
      @(negedge clk_in);
      cfg_req_out = '{valid: 1'b1, write: wr, offset: ofs, byte_en: be, wdata: wd};
      @(negedge clk_in);
      rd = cfg_rdata_in;
      ok = cfg_ack_in;
      cfg_req_out = '{valid: 1'b0, write: ~wr, offset: ~ofs, byte_en: ~be, wdata: ~wd};
   endtask
endmodule // bxc_host_model
`default_nettype wire

// ==== tb/bxc_config_regs_tb.sv ====
// Self-checking bench of the extension register block
`default_nettype none
module bxc_config_regs_tb
   import bxc_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   logic         clk_in;
   logic         reset_in;
   bxc_cfg_req_s cfg_req;
   logic         cfg_ack;
   logic [31:0]  cfg_rdata;
   logic         bit6_clear;
   logic         bit6;
   logic         int_rst;
   logic [4:0]   request;
   wire  [4:0]   grant;
   bxc_txn_s     txn;
   logic [1:0]   hit;
   logic [1:0]   claim;
   logic [1:0]   pref;
   logic [31:0]  rd_v;
   logic         ack_v;
   logic [15:0]  arb_val;
   int           n_errors;
   int           checked;
   int           cycles;

   bxc_config_regs dut (.clk_in(clk_in), .reset_in(reset_in), .cfg_req_in(cfg_req),
      .cfg_ack_out(cfg_ack), .cfg_rdata_out(cfg_rdata), .bridge_ctl_bit6_clear_in(bit6_clear),
      .bridge_ctl_bit6_out(bit6), .internal_reset_out(int_rst), .request_in(request),
      .bridge_grant_out(grant[4]), .secondary_grant_line_0_out(grant[0]),
      .secondary_grant_line_1_out(grant[1]), .secondary_grant_line_2_out(grant[2]),
      .secondary_grant_line_3_out(grant[3]), .txn_in(txn), .window_hit_out(hit),
      .window_primary_claim_out(claim), .window_prefetch_out(pref));
   bxc_host_model host (.clk_in(clk_in), .cfg_req_out(cfg_req), .cfg_ack_in(cfg_ack),
      .cfg_rdata_in(cfg_rdata));

   // ==========================================================
   // Clock, timeout and shared tasks
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         results();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0d ns: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] ofs, input logic [3:0] be, input logic [31:0] d);
      host.access(1'b1, ofs, be, d, rd_v, ack_v);
      check({31'h0, ack_v}, 32'h1);
   endtask
   task automatic rd_chk(input logic [7:0] ofs, input logic [31:0] exp);
      host.access(1'b0, ofs, 4'hf, 32'h0, rd_v, ack_v);
      check({31'h0, ack_v}, 32'h1);
      check(rd_v, exp);
   endtask
   task automatic probe(input logic [31:0] a, input logic io, input logic [5:0] exp);
      @(negedge clk_in);
      txn = '{addr: a, is_io: io};
      repeat (2) @(negedge clk_in);
      check({26'h0, pref & hit, claim, hit}, {26'h0, exp});
   endtask
   task automatic drive_req(input logic [4:0] req, input logic [4:0] exp);
      @(negedge clk_in);
      request = req;
      repeat (5) @(negedge clk_in);
      check({27'h0, grant}, {27'h0, exp});
   endtask
   task automatic results();
      $display("Comparisons %0d, mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      reset_in = 1'b1;
      request = 5'h00;
      txn = '0;
      bit6_clear = 1'b0;
      n_errors = 0;
      checked = 0;
      cycles = 0;
      repeat (8) @(negedge clk_in);
      reset_in = 1'b0;
      rd_chk(8'h40, 32'h0200_0000);
      for (int k = 0; k < 5; k++) rd_chk(8'h44 + 8'(4 * k), 32'h0);
      wr(8'h58, 4'hf, 32'hffff_ffff);
      rd_chk(8'h58, 32'h0);
      wr(8'h40, 4'hc, 32'hffff_0000);
      rd_chk(8'h40, 32'h020f_0000);
      for (int k = 0; k < 5; k++) begin
         arb_val = (k < 4) ? (16'h0001 << k) : ARB_RESET;
         wr(8'h40, 4'hc, {arb_val, 16'h0000});
         drive_req(5'h1f, 5'h01 << k);
         drive_req(5'h00, 5'h00);
      end
      drive_req(5'h03, 5'h01);
      drive_req(5'h00, 5'h00);
      drive_req(5'h03, 5'h02);
      wr(8'h44, 4'hf, 32'h1000_0abf);
      wr(8'h48, 4'hf, 32'h1000_0001);
      wr(8'h4c, 4'hf, 32'h0000_2005);
      wr(8'h50, 4'hf, 32'h0000_2006);
      rd_chk(8'h44, 32'h1000_0abc);
      rd_chk(8'h4c, 32'h0000_2004);
      probe(32'h1000_0000, 1'b0, 6'h00);
      wr(8'h54, 4'h1, 32'h0000_0003);
      rd_chk(8'h54, 32'h0000_0003);
      probe(32'h1000_0000, 1'b0, 6'h15);
      probe(32'h0fff_fffc, 1'b0, 6'h00);
      probe(32'h1000_0fff, 1'b0, 6'h15);
      probe(32'h1000_1000, 1'b0, 6'h00);
      probe(32'h1000_0800, 1'b1, 6'h00);
      probe(32'h0000_2004, 1'b1, 6'h0a);
      probe(32'h0000_2007, 1'b1, 6'h0a);
      probe(32'h0000_2003, 1'b1, 6'h00);
      probe(32'h0000_2008, 1'b1, 6'h00);
      probe(32'h0000_2004, 1'b0, 6'h00);
      wr(8'h54, 4'h2, 32'h0000_0100);
      probe(32'h1000_0000, 1'b0, 6'h11);
      wr(8'h48, 4'hf, 32'h1000_0000);
      probe(32'h1000_0fff, 1'b0, 6'h01);
      wr(8'h48, 4'hf, 32'h1000_0aff);
      probe(32'h1000_0abc, 1'b1, 6'h01);
      probe(32'h1000_0b00, 1'b1, 6'h00);
      wr(8'h40, 4'h2, 32'h0000_0100);
      @(negedge clk_in);
      check({30'h0, bit6, int_rst}, 32'h3);
      wr(8'h44, 4'hf, 32'hffff_ffff);
      for (int i = 0; i < 40 && int_rst !== 1'b0; i++) @(negedge clk_in);
      check({31'h0, int_rst}, 32'h0);
      rd_chk(8'h44, 32'h0);
      rd_chk(8'h54, 32'h0);
      rd_chk(8'h40, 32'h0200_0000);
      check({31'h0, bit6}, 32'h1);
      bit6_clear = 1'b1;
      @(negedge clk_in);
      bit6_clear = 1'b0;
      @(negedge clk_in);
      check({31'h0, bit6}, 32'h0);
      results();
   end
endmodule // bxc_config_regs_tb
`default_nettype wire
